// [rtl/addr_map_pkg.sv]
// address map constants, access widths and target codes for the decoder
// assumes host addresses are byte addresses, dsp addresses are 24 bits
package addr_map_pkg;

	// access widths; ACC_NONE marks "no width check"
	typedef enum logic [1:0] {ACC_W8, ACC_W16, ACC_W32, ACC_NONE} acc_width_t;

	typedef enum logic [2:0] {
		HT_MEMORY, HT_DSP_MEM, HT_DSP_PERIPH, HT_PRIV_PERIPH,
		HT_PUB_PERIPH, HT_SHARED_PERIPH, HT_CONFIG, HT_UNMAPPED
	} host_target_t;

	typedef enum logic [2:0] {
		DT_DUAL_RAM, DT_SINGLE_RAM, DT_RESERVED, DT_MMU, DT_PROG_ROM, DT_IO
	} dsp_target_t;

	// host address top byte boundaries
	localparam logic [7:0] TOP_DSP_MEM = 8'he0;

	// register set pages: host address bits 31..8, 256 bytes each
	localparam logic [23:0] PG_L2_IRQ = 24'hfffe00;
	localparam logic [23:0] PG_L1_IRQ = 24'hfffecb;
	localparam logic [23:0] PG_TIMER1 = 24'hfffec5;
	localparam logic [23:0] PG_TIMER2 = 24'hfffec6;
	localparam logic [23:0] PG_TIMER3 = 24'hfffec7;
	localparam logic [23:0] PG_WATCHDOG = 24'hfffec8;
	localparam logic [23:0] PG_SYS_DMA = 24'hfffed8;
	localparam logic [23:0] PG_TONE = 24'hfffb60;
	localparam logic [23:0] PG_BACKLIGHT = 24'hfffb58;
	localparam logic [23:0] PG_RTC = 24'hfffb48;
	localparam logic [23:0] PG_BATT_LINK = 24'hfffbc0;
	localparam logic [23:0] PG_LED1 = 24'hfffbd0;
	localparam logic [23:0] PG_LED2 = 24'hfffbd8;
	localparam logic [23:0] PG_FRAME_ADJ = 24'hfffba8;
	localparam logic [23:0] PG_SERIAL1 = 24'hfffb00;
	localparam logic [23:0] PG_SERIAL2 = 24'hfffb08;
	localparam logic [23:0] PG_SERIAL3 = 24'hfffb98;
	localparam logic [23:0] PG_GPIO = 24'hfffce0;
	localparam logic [23:0] PG_MAILBOX = 24'hfffcf0;
	localparam logic [23:0] PG_DSP_BSP1 = 24'he10118;
	localparam logic [23:0] PG_DSP_VSP2 = 24'he10120;
	localparam logic [23:0] PG_DSP_VSP1 = 24'he10128;
	localparam logic [23:0] PG_DSP_BSP3 = 24'he10170;
	localparam logic [23:0] PG_LOW_POWER = 24'hfffe08;
	localparam logic [23:0] PG_TRAFFIC = 24'hfffecc;

	// dsp program/data map, byte addresses
	localparam logic [23:0] DSP_DUAL_ACCESS_RAM_BASE = 24'h000000;
	localparam logic [23:0] DSP_SINGLE_ACCESS_RAM_BASE = 24'h010000;
	localparam logic [23:0] DSP_RSVD_BASE = 24'h028000;
	localparam logic [23:0] DSP_MMU_BASE = 24'h050000;
	localparam logic [23:0] DSP_ROM_BASE = 24'hff8000;
	localparam int DSP_BLOCK_LSB = 13;

	// 8k-byte block index of an address inside a ram
	function automatic logic [3:0] ram_block(input logic [23:0] a,
		input logic [23:0] base);
		logic [23:0] off;
		off = a - base;
		return off[DSP_BLOCK_LSB +: 4];
	endfunction

endpackage

// [rtl/host_window_lookup.sv]
// register set lookup for one host byte address page
// assumes page is host address bits 31..8; purely combinational
`timescale 1ns/1ps
module host_window_lookup
	import addr_map_pkg::*;
(
	input wire logic [23:0] i_page, // host address bits 31..8
	output logic o_hit, // page holds a register set
	output addr_map_pkg::acc_width_t o_width, // width the set needs
	output addr_map_pkg::host_target_t o_target // peripheral group
);
	always_comb
	begin
		o_hit = 1'b1;
		o_width = ACC_W32;
		o_target = HT_PRIV_PERIPH;
		case (i_page)
			PG_L2_IRQ, PG_L1_IRQ, PG_TIMER1, PG_TIMER2, PG_TIMER3,
			PG_WATCHDOG: o_width = ACC_W32;
			PG_SYS_DMA: o_width = ACC_W16;
			PG_TONE, PG_BACKLIGHT, PG_RTC, PG_BATT_LINK, PG_LED1, PG_LED2:
			begin
				o_width = ACC_W8;
				o_target = HT_PUB_PERIPH;
			end
			PG_FRAME_ADJ:
			begin
				o_width = ACC_W16;
				o_target = HT_PUB_PERIPH;
			end
			PG_SERIAL1, PG_SERIAL2, PG_SERIAL3:
			begin
				o_width = ACC_W8;
				o_target = HT_SHARED_PERIPH;
			end
			PG_GPIO, PG_MAILBOX:
			begin
				o_width = ACC_W16;
				o_target = HT_SHARED_PERIPH;
			end
			PG_DSP_BSP1, PG_DSP_VSP2, PG_DSP_VSP1, PG_DSP_BSP3:
			begin
				o_width = ACC_W16;
				o_target = HT_DSP_PERIPH;
			end
			PG_LOW_POWER:
			begin
				o_width = ACC_W16;
				o_target = HT_CONFIG;
			end
			PG_TRAFFIC: o_target = HT_CONFIG;
			default:
			begin
				o_hit = 1'b0;
				o_width = ACC_NONE;
				o_target = HT_UNMAPPED;
			end
		endcase
	end
endmodule // host_window_lookup

// [rtl/dsp_map_decoder.sv]
// decode of one dsp program, data or i/o access
// assumes 24-bit addresses; data addresses are word addresses
`timescale 1ns/1ps
module dsp_map_decoder
	import addr_map_pkg::*;
(
	input wire logic [23:0] i_addr, // dsp address
	input wire logic i_is_data, // data access, word address
	input wire logic i_is_io, // port instruction access
	input wire logic i_rom_mode, // mode select, synchronised
	output addr_map_pkg::dsp_target_t o_target, // decoded target
	output logic [3:0] o_block // ram block index
);
	logic [23:0] byte_addr;

	// data word address to byte address
	assign byte_addr = i_is_data ? {i_addr[22:0], 1'b0} : i_addr;

	always_comb
	begin
		o_block = 4'h0;
		if (i_is_io)
			o_target = DT_IO;
		else if (byte_addr < DSP_SINGLE_ACCESS_RAM_BASE)
		begin
			o_target = DT_DUAL_RAM;
			o_block = ram_block(byte_addr, DSP_DUAL_ACCESS_RAM_BASE);
		end
		else if (byte_addr < DSP_RSVD_BASE)
		begin
			o_target = DT_SINGLE_RAM;
			o_block = ram_block(byte_addr, DSP_SINGLE_ACCESS_RAM_BASE);
		end
		else if (byte_addr < DSP_MMU_BASE)
			o_target = DT_RESERVED;
		else if (byte_addr < DSP_ROM_BASE)
			o_target = DT_MMU;
		else if (!i_rom_mode)
			o_target = DT_PROG_ROM;
		else
			o_target = DT_MMU;
	end
endmodule // dsp_map_decoder

// [rtl/dual_core_address_decoder.sv]
// address decoder for the host and signal processor maps
// assumes requests come from logic on i_core_clk; mode pin is asynchronous
// What this block does
// - peripheral sets sit in host memory space
// - wrong width gives bus error and interrupt
// - level-2 interrupt set at fffe0000, 32-bit
// - level-1 irq, timers, watchdog are 32-bit
// - system dma set at fffed800, 16-bit only
// - tone, backlight, rtc, battery, leds are 8-bit
// - frame adjust counter at fffba800, 16-bit
// - serial ports 8-bit; gpio, mailbox 16-bit
// - dsp peripherals via host port, 16-bit
// - low power 16-bit, traffic controller 32-bit
// - dsp peripherals in separate i/o space
// - dsp data word-addressed, program byte-addressed
// - dual ram 0-ffff in eight 8k blocks
// - each dual ram block takes two accesses
// - shared sram and external only via mmu
// - host reaches dsp rams through host port
// - top 32k is rom or mmu by mode
// - 050000 to ff7fff forwarded through mmu
// - host addresses are byte addresses
`timescale 1ns/1ps
module dual_core_address_decoder
	import addr_map_pkg::*;
(
	input wire logic i_core_clk, // core clock, 50 MHz
	input wire logic i_sys_rst, // synchronous reset, active high
	input wire logic i_clk_en, // freezes all state while low
	input wire logic i_host_req, // host request strobe
	input wire logic [31:0] i_host_addr, // host byte address
	input wire addr_map_pkg::acc_width_t i_host_size, // access width used
	input wire logic i_mp_mode, // microprocessor_mode_select pin
	input wire logic i_dsp_a_req, // dsp port a request
	input wire logic [23:0] i_dsp_a_addr, // dsp port a address
	input wire logic i_dsp_a_data, // port a data (word) access
	input wire logic i_dsp_a_io, // port a i/o space access
	input wire logic i_dsp_b_req, // dsp port b request
	input wire logic [23:0] i_dsp_b_addr, // dsp port b address
	input wire logic i_dsp_b_data, // port b data (word) access
	input wire logic i_dsp_b_io, // port b i/o space access
	output logic o_host_ack, // host answer pulse
	output logic o_host_err, // host bus error, with ack
	output addr_map_pkg::host_target_t o_host_target, // host target
	output addr_map_pkg::acc_width_t o_host_width, // width the set needs
	output logic o_host_dsp_port, // routed through host_to_dsp_port
	output logic o_pbus_irq, // peripheral_bus error interrupt pulse
	output logic o_dsp_a_ack, // port a answer pulse
	output logic o_dsp_a_err, // port a error, with ack
	output addr_map_pkg::dsp_target_t o_dsp_a_target, // port a target
	output logic [3:0] o_dsp_a_block, // port a ram block
	output logic o_dsp_b_ack, // port b answer pulse
	output logic o_dsp_b_err, // port b error, with ack
	output addr_map_pkg::dsp_target_t o_dsp_b_target, // port b target
	output logic [3:0] o_dsp_b_block, // port b ram block
	output logic o_single_ram_conflict // both ports hit one single ram block
);
	typedef struct packed {
		logic mode_meta;
		logic mode_sync;
		logic host_ack;
		logic host_err;
		logic pbus_irq;
		logic dsp_port;
		host_target_t host_target;
		acc_width_t host_width;
		logic a_ack;
		logic a_err;
		dsp_target_t a_target;
		logic [3:0] a_block;
		logic b_ack;
		logic b_err;
		dsp_target_t b_target;
		logic [3:0] b_block;
		logic conflict;
	} state_t;

	localparam state_t ST_RESET = '0;

	state_t st_q;
	state_t st_d;

	logic lk_hit;
	acc_width_t lk_width;
	host_target_t lk_target;
	logic [23:0] host_page;
	logic [7:0] host_top;
	dsp_target_t a_target;
	dsp_target_t b_target;
	logic [3:0] a_block;
	logic [3:0] b_block;
	logic host_take;
	logic a_take;
	logic b_take;

	// byte address split into page and top byte
	assign host_page = i_host_addr[31:8];
	assign host_top = i_host_addr[31:24];
	assign host_take = i_host_req & i_clk_en;
	assign a_take = i_dsp_a_req & i_clk_en;
	assign b_take = i_dsp_b_req & i_clk_en;

	host_window_lookup u_lookup (
		.i_page(host_page),
		.o_hit(lk_hit),
		.o_width(lk_width),
		.o_target(lk_target)
	);

	// two decoders so both accesses resolve in one cycle
	dsp_map_decoder u_dsp_a (
		.i_addr(i_dsp_a_addr),
		.i_is_data(i_dsp_a_data),
		.i_is_io(i_dsp_a_io),
		.i_rom_mode(st_q.mode_sync),
		.o_target(a_target),
		.o_block(a_block)
	);

	dsp_map_decoder u_dsp_b (
		.i_addr(i_dsp_b_addr),
		.i_is_data(i_dsp_b_data),
		.i_is_io(i_dsp_b_io),
		.i_rom_mode(st_q.mode_sync),
		.o_target(b_target),
		.o_block(b_block)
	);

	always_comb
	begin
		st_d = st_q;
		// mode pin through two flops
		st_d.mode_meta = i_mp_mode;
		st_d.mode_sync = st_q.mode_meta;
		st_d.host_ack = i_host_req;
		st_d.host_err = 1'b0;
		st_d.pbus_irq = 1'b0;
		st_d.dsp_port = 1'b0;
		st_d.host_target = HT_MEMORY;
		st_d.host_width = ACC_NONE;
		if (i_host_req)
		begin
			if (host_top < TOP_DSP_MEM)
				st_d.host_target = HT_MEMORY;
			else if (host_top == TOP_DSP_MEM)
			begin
				st_d.host_target = HT_DSP_MEM;
				st_d.dsp_port = 1'b1;
			end
			else if (lk_hit)
			begin
				st_d.host_target = lk_target;
				st_d.host_width = lk_width;
				st_d.dsp_port = (lk_target == HT_DSP_PERIPH);
				st_d.host_err = (i_host_size != lk_width);
				st_d.pbus_irq = (i_host_size != lk_width);
			end
			else
			begin
				st_d.host_target = HT_UNMAPPED;
				st_d.host_err = 1'b1;
			end
		end
		// both ports decoded and answered in the same cycle
		st_d.a_ack = i_dsp_a_req;
		st_d.b_ack = i_dsp_b_req;
		st_d.a_target = a_target;
		st_d.b_target = b_target;
		st_d.a_block = a_block;
		st_d.b_block = b_block;
		st_d.a_err = i_dsp_a_req && (a_target == DT_RESERVED);
		st_d.b_err = i_dsp_b_req && (b_target == DT_RESERVED);
		// single ram blocks serve one access per cycle
		st_d.conflict = i_dsp_a_req && i_dsp_b_req
			&& (a_target == DT_SINGLE_RAM) && (b_target == DT_SINGLE_RAM)
			&& (a_block == b_block);
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_sys_rst)
			st_q <= ST_RESET;
		else if (i_clk_en)
			st_q <= st_d;
	end

	assign o_host_ack = st_q.host_ack;
	assign o_host_err = st_q.host_err;
	assign o_host_target = st_q.host_target;
	assign o_host_width = st_q.host_width;
	assign o_host_dsp_port = st_q.dsp_port;
	assign o_pbus_irq = st_q.pbus_irq;
	assign o_dsp_a_ack = st_q.a_ack;
	assign o_dsp_a_err = st_q.a_err;
	assign o_dsp_a_target = st_q.a_target;
	assign o_dsp_a_block = st_q.a_block;
	assign o_dsp_b_ack = st_q.b_ack;
	assign o_dsp_b_err = st_q.b_err;
	assign o_dsp_b_target = st_q.b_target;
	assign o_dsp_b_block = st_q.b_block;
	assign o_single_ram_conflict = st_q.conflict;

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_sys_rst);

	sequence host_taken;
		host_take;
	endsequence

	sequence host_answered_err;
		o_host_ack && o_host_err;
	endsequence

	sequence a_plain_byte;
		a_take && !i_dsp_a_io && !i_dsp_a_data;
	endsequence

	sequence b_plain_byte;
		b_take && !i_dsp_b_io && !i_dsp_b_data;
	endsequence

	chk_width_error_irq: assert property (
		host_taken ##0 (host_top > TOP_DSP_MEM && lk_hit
			&& i_host_size != lk_width)
		|=> host_answered_err and o_pbus_irq)
		else $error("wrong access width not flagged");

	chk_right_width_ok: assert property (
		host_taken ##0 (host_top > TOP_DSP_MEM && lk_hit
			&& i_host_size == lk_width)
		|=> o_host_ack && !o_host_err && !o_pbus_irq)
		else $error("correct width access flagged as error");

	chk_sys_dma_width: assert property (
		host_taken ##0 (host_page == PG_SYS_DMA)
		|=> o_host_width == ACC_W16 && o_host_target == HT_PRIV_PERIPH)
		else $error("system dma set not 16-bit private");

	chk_l2_irq_width: assert property (
		host_taken ##0 (host_page == PG_L2_IRQ && i_host_size == ACC_W16)
		|=> host_answered_err)
		else $error("16-bit access to interrupt set accepted");

	chk_tone_width: assert property (
		host_taken ##0 (host_page == PG_TONE)
		|=> o_host_width == ACC_W8 && o_host_target == HT_PUB_PERIPH)
		else $error("tone set not 8-bit public");

	chk_dsp_port_route: assert property (
		host_taken ##0 (host_page == PG_DSP_BSP1)
		|=> o_host_dsp_port && o_host_width == ACC_W16)
		else $error("dsp peripheral not routed through host port");

	chk_unmapped_error: assert property (
		host_taken ##0 (host_top > TOP_DSP_MEM && !lk_hit)
		|=> host_answered_err ##0 !o_pbus_irq
			##1 (!o_host_ack || !o_host_err || $past(host_take)
			|| !$past(i_clk_en)))
		else $error("unmapped access not ended in error");

	chk_host_ack_pulse: assert property (
		host_taken ##1 (!i_host_req && i_clk_en)
		|-> o_host_ack ##1 !o_host_ack)
		else $error("host answer is not a one-cycle pulse");

	chk_io_space: assert property (
		a_take && i_dsp_a_io
		|=> o_dsp_a_target == DT_IO && !o_dsp_a_err)
		else $error("port instruction not decoded to i/o space");

	chk_word_address: assert property (
		a_take && i_dsp_a_data && !i_dsp_a_io
			&& i_dsp_a_addr >= DSP_SINGLE_ACCESS_RAM_BASE[23:1]
			&& i_dsp_a_addr < DSP_RSVD_BASE[23:1]
		|=> o_dsp_a_target == DT_SINGLE_RAM)
		else $error("data word address not scaled to bytes");

	chk_dual_ram_block: assert property (
		a_plain_byte ##0 (i_dsp_a_addr < DSP_SINGLE_ACCESS_RAM_BASE)
		|=> o_dsp_a_target == DT_DUAL_RAM
			&& o_dsp_a_block == $past(i_dsp_a_addr[15:13]))
		else $error("dual ram block index wrong");

	chk_dual_access: assert property (
		a_plain_byte ##0 b_plain_byte ##0
			(i_dsp_a_addr < DSP_SINGLE_ACCESS_RAM_BASE && i_dsp_b_addr < DSP_SINGLE_ACCESS_RAM_BASE
			&& i_dsp_a_addr[15:13] == i_dsp_b_addr[15:13])
		|=> o_dsp_a_ack && o_dsp_b_ack && !o_dsp_a_err && !o_dsp_b_err
			&& !o_single_ram_conflict)
		else $error("dual ram block refused a second access");

	chk_rom_by_mode: assert property (
		a_plain_byte ##0 (i_dsp_a_addr >= DSP_ROM_BASE)
		|=> o_dsp_a_target == ($past(st_q.mode_sync) ? DT_MMU : DT_PROG_ROM))
		else $error("top region not steered by mode select");

	chk_mmu_region: assert property (
		b_plain_byte ##0 (i_dsp_b_addr >= DSP_MMU_BASE
			&& i_dsp_b_addr < DSP_ROM_BASE)
		|=> o_dsp_b_target == DT_MMU && !o_dsp_b_err)
		else $error("mmu region not forwarded");

	chk_reserved_hole: assert property (
		b_plain_byte ##0 (i_dsp_b_addr >= DSP_RSVD_BASE
			&& i_dsp_b_addr < DSP_MMU_BASE)
		|=> o_dsp_b_ack && o_dsp_b_err)
		else $error("reserved dsp hole not ended in error");

	chk_timer_width: assert property (
		host_taken ##0 (host_page == PG_TIMER2 || host_page == PG_WATCHDOG
			|| host_page == PG_L1_IRQ)
		|=> o_host_width == ACC_W32 && o_host_target == HT_PRIV_PERIPH)
		else $error("timer or level-1 set not 32-bit private");

	chk_frame_adj_width: assert property (
		host_taken ##0 (host_page == PG_FRAME_ADJ)
		|=> o_host_width == ACC_W16 && o_host_target == HT_PUB_PERIPH)
		else $error("frame adjust set not 16-bit public");

	chk_shared_width: assert property (
		host_taken ##0 (host_page == PG_SERIAL3 || host_page == PG_GPIO)
		|=> o_host_target == HT_SHARED_PERIPH
			&& o_host_width == (($past(host_page) == PG_GPIO)
			? ACC_W16 : ACC_W8))
		else $error("shared set width or group wrong");

	chk_config_width: assert property (
		host_taken ##0 (host_page == PG_LOW_POWER
			|| host_page == PG_TRAFFIC)
		|=> o_host_target == HT_CONFIG
			&& o_host_width == (($past(host_page) == PG_TRAFFIC)
			? ACC_W32 : ACC_W16))
		else $error("configuration set width or group wrong");

	chk_dsp_mem_route: assert property (
		host_taken ##0 (host_top == TOP_DSP_MEM)
		|=> o_host_target == HT_DSP_MEM && o_host_dsp_port && !o_host_err)
		else $error("dsp memory not reached through host port");

	chk_memory_pass: assert property (
		host_taken ##0 (host_top < TOP_DSP_MEM)
		|=> o_host_target == HT_MEMORY && o_host_ack && !o_host_err)
		else $error("memory access not passed through");

	chk_single_conflict: assert property (
		a_plain_byte ##0 b_plain_byte ##0 (i_dsp_a_addr >= DSP_SINGLE_ACCESS_RAM_BASE
			&& i_dsp_a_addr < DSP_RSVD_BASE
			&& i_dsp_a_addr == i_dsp_b_addr)
		|=> o_single_ram_conflict && o_dsp_a_ack && o_dsp_b_ack)
		else $error("single ram double access not flagged");

	chk_frozen_hold: assert property (
		!i_clk_en |=> $stable(o_host_ack) && $stable(o_pbus_irq)
			&& $stable(o_dsp_a_ack) && $stable(o_dsp_b_ack))
		else $error("answers moved while clock enable low");

endmodule // dual_core_address_decoder

// [tb/host_master_model.sv]
// host master model: issues one access per call on the host request port
// assumes the decoder samples on the rising edge of i_core_clk
`timescale 1ns/1ps
module host_master_model
	import addr_map_pkg::*;
(
	input wire logic i_core_clk, // core clock
	output logic o_host_req, // request strobe
	output logic [31:0] o_host_addr, // byte address
	output addr_map_pkg::acc_width_t o_host_size // width used
);
	initial
	begin
		o_host_req = 1'b0;
		o_host_addr = 32'h0000_0000;
		o_host_size = ACC_NONE;
	end

	// one-cycle strobe, width as commanded by the scenario
	task automatic access(input logic [31:0] a, input acc_width_t s);
		@(negedge i_core_clk);
		o_host_req = 1'b1;
		o_host_addr = a;
		o_host_size = s;
		@(negedge i_core_clk);
		o_host_req = 1'b0;
		// released bus shows no stale value
		o_host_addr = ~a;
	endtask
endmodule // host_master_model

// [tb/tb_top.sv]
// self-checking bench for the dual core address decoder
// assumes addr_map_pkg and the decoder sources are compiled first
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
	fails++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_top;
	import addr_map_pkg::*;
	logic i_core_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_clk_en = 1'b1;
	logic i_mp_mode = 1'b0;
	logic host_req;
	logic [31:0] host_addr;
	acc_width_t host_size;
	logic da_req = 1'b0, db_req = 1'b0, da_data = 1'b0, db_data = 1'b0;
	logic da_io = 1'b0, db_io = 1'b0;
	logic [23:0] da_addr = 24'h000000, db_addr = 24'h000000;
	logic o_host_ack, o_host_err, o_host_dsp_port, o_pbus_irq;
	host_target_t o_host_target;
	acc_width_t o_host_width;
	logic o_dsp_a_ack, o_dsp_a_err, o_dsp_b_ack, o_dsp_b_err, o_conf;
	dsp_target_t o_dsp_a_target, o_dsp_b_target;
	logic [3:0] o_dsp_a_block, o_dsp_b_block;
	int fails = 0;
	int check_count = 0;

	always #10 i_core_clk = ~i_core_clk;

	host_master_model host_u (
		.i_core_clk(i_core_clk),
		.o_host_req(host_req),
		.o_host_addr(host_addr),
		.o_host_size(host_size)
	);

	dual_core_address_decoder dut_u (
		.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
		.i_host_req(host_req), .i_host_addr(host_addr),
		.i_host_size(host_size), .i_mp_mode(i_mp_mode),
		.i_dsp_a_req(da_req), .i_dsp_a_addr(da_addr),
		.i_dsp_a_data(da_data), .i_dsp_a_io(da_io),
		.i_dsp_b_req(db_req), .i_dsp_b_addr(db_addr),
		.i_dsp_b_data(db_data), .i_dsp_b_io(db_io),
		.o_host_ack(o_host_ack), .o_host_err(o_host_err),
		.o_host_target(o_host_target), .o_host_width(o_host_width),
		.o_host_dsp_port(o_host_dsp_port), .o_pbus_irq(o_pbus_irq),
		.o_dsp_a_ack(o_dsp_a_ack), .o_dsp_a_err(o_dsp_a_err),
		.o_dsp_a_target(o_dsp_a_target), .o_dsp_a_block(o_dsp_a_block),
		.o_dsp_b_ack(o_dsp_b_ack), .o_dsp_b_err(o_dsp_b_err),
		.o_dsp_b_target(o_dsp_b_target), .o_dsp_b_block(o_dsp_b_block),
		.o_single_ram_conflict(o_conf)
	);

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// one host access, answer judged on the falling edge after it is taken
	task automatic host_case(input logic [31:0] a, input acc_width_t s,
		input logic e, input logic q, input host_target_t t,
		input acc_width_t w, input logic p);
		host_u.access(a, s);
		`CHK("host_ack", 1'b1, o_host_ack)
		`CHK("host_err", e, o_host_err)
		`CHK("pbus_irq", q, o_pbus_irq)
		`CHK("host_target", t, o_host_target)
		`CHK("host_width", w, o_host_width)
		`CHK("host_dsp_port", p, o_host_dsp_port)
	endtask

	// same access on both dsp ports in one cycle
	task automatic dsp_case(input logic [23:0] a, input logic d,
		input logic io, input dsp_target_t t, input logic [3:0] b,
		input logic e, input logic c);
		@(negedge i_core_clk);
		{da_req, db_req, da_addr, db_addr} = {2'b11, a, a};
		{da_data, db_data, da_io, db_io} = {d, d, io, io};
		@(negedge i_core_clk);
		{da_req, db_req, da_addr, db_addr} = {2'b00, ~a, ~a};
		`CHK("dsp_a_ack", 1'b1, o_dsp_a_ack)
		`CHK("dsp_b_ack", 1'b1, o_dsp_b_ack)
		`CHK("dsp_a_err", e, o_dsp_a_err)
		`CHK("dsp_b_err", e, o_dsp_b_err)
		`CHK("dsp_a_target", t, o_dsp_a_target)
		`CHK("dsp_b_target", t, o_dsp_b_target)
		`CHK("dsp_a_block", b, o_dsp_a_block)
		`CHK("dsp_b_block", b, o_dsp_b_block)
		`CHK("ram_conflict", c, o_conf)
	endtask

	task automatic test_reset();
		@(negedge i_core_clk);
		`CHK("rst_ack", 1'b0, o_host_ack)
		`CHK("rst_target", HT_MEMORY, o_host_target)
		$display("test reset done");
	endtask

	task automatic test_host_map();
		host_case(32'hfffe0000, ACC_W32, 0, 0, HT_PRIV_PERIPH, ACC_W32, 0);
		host_case(32'hfffe0000, ACC_W8, 1, 1, HT_PRIV_PERIPH, ACC_W32, 0);
		host_case(32'hfffecb00, ACC_W32, 0, 0, HT_PRIV_PERIPH, ACC_W32, 0);
		host_case(32'hfffec700, ACC_W16, 1, 1, HT_PRIV_PERIPH, ACC_W32, 0);
		host_case(32'hfffec800, ACC_W32, 0, 0, HT_PRIV_PERIPH, ACC_W32, 0);
		host_case(32'hfffed800, ACC_W16, 0, 0, HT_PRIV_PERIPH, ACC_W16, 0);
		host_case(32'hfffed800, ACC_W32, 1, 1, HT_PRIV_PERIPH, ACC_W16, 0);
		host_case(32'hfffb6000, ACC_W8, 0, 0, HT_PUB_PERIPH, ACC_W8, 0);
		host_case(32'hfffbd8ff, ACC_W16, 1, 1, HT_PUB_PERIPH, ACC_W8, 0);
		host_case(32'hfffba800, ACC_W16, 0, 0, HT_PUB_PERIPH, ACC_W16, 0);
		host_case(32'hfffb9800, ACC_W8, 0, 0, HT_SHARED_PERIPH, ACC_W8, 0);
		host_case(32'hfffce000, ACC_W32, 1, 1, HT_SHARED_PERIPH, ACC_W16, 0);
		host_case(32'he1011800, ACC_W16, 0, 0, HT_DSP_PERIPH, ACC_W16, 1);
		host_case(32'he1017000, ACC_W8, 1, 1, HT_DSP_PERIPH, ACC_W16, 1);
		host_case(32'hfffe0800, ACC_W16, 0, 0, HT_CONFIG, ACC_W16, 0);
		host_case(32'hfffecc00, ACC_W32, 0, 0, HT_CONFIG, ACC_W32, 0);
		host_case(32'h20000000, ACC_W8, 0, 0, HT_MEMORY, ACC_NONE, 0);
		host_case(32'he0001000, ACC_W32, 0, 0, HT_DSP_MEM, ACC_NONE, 1);
		host_case(32'hffff0000, ACC_W32, 1, 0, HT_UNMAPPED, ACC_NONE, 0);
		$display("test host_map done");
	endtask

	// request seen while frozen is not taken
	task automatic test_freeze();
		@(negedge i_core_clk);
		i_clk_en = 1'b0;
		host_u.access(32'hfffe0000, ACC_W8);
		`CHK("frozen_ack", 1'b0, o_host_ack)
		`CHK("frozen_irq", 1'b0, o_pbus_irq)
		i_clk_en = 1'b1;
		$display("test freeze done");
	endtask

	task automatic test_dsp_map();
		dsp_case(24'h00a000, 0, 0, DT_DUAL_RAM, 4'h5, 0, 0);
		dsp_case(24'h00fffe, 0, 0, DT_DUAL_RAM, 4'h7, 0, 0);
		dsp_case(24'h008000, 0, 0, DT_DUAL_RAM, 4'h4, 0, 0);
		dsp_case(24'h008000, 1, 0, DT_SINGLE_RAM, 4'h0, 0, 1);
		dsp_case(24'h026000, 0, 0, DT_SINGLE_RAM, 4'hb, 0, 1);
		dsp_case(24'h028000, 0, 0, DT_RESERVED, 4'h0, 1, 0);
		dsp_case(24'h050000, 0, 0, DT_MMU, 4'h0, 0, 0);
		dsp_case(24'hff7fff, 0, 0, DT_MMU, 4'h0, 0, 0);
		dsp_case(24'h7fc000, 1, 0, DT_PROG_ROM, 4'h0, 0, 0);
		dsp_case(24'h00a000, 0, 1, DT_IO, 4'h0, 0, 0);
		@(negedge i_core_clk);
		i_mp_mode = 1'b1;
		repeat (4) @(negedge i_core_clk);
		dsp_case(24'hff8000, 0, 0, DT_MMU, 4'h0, 0, 0);
		$display("test dsp_map done");
	endtask

	initial
	begin
		repeat (16) @(posedge i_core_clk);
		test_reset();
		i_sys_rst = 1'b0;
		test_host_map();
		test_freeze();
		test_dsp_map();
		summarize();
	end

	// all tests take well under 400 cycles
	initial
	begin
		repeat (2000) @(posedge i_core_clk);
		fails++;
		summarize();
	end
endmodule // tb_top
